// >>> rtl/scr_consts.vh
// Constants for the splitter command redirector
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SCR_OFF_TYPE        6'h00
`define SCR_OFF_OWN_CHAN    6'h04
`define SCR_OFF_CMD_OP      6'h08
`define SCR_OFF_CMD_CHAN    6'h0c
`define SCR_OFF_CMD_TARGET  6'h10
`define SCR_OFF_CMD_VALUE   6'h14
`define SCR_OFF_GO          6'h18
`define SCR_OFF_STATUS      6'h1c
`define SCR_OFF_REP_CHAN    6'h20
`define SCR_OFF_REP_TARGET  6'h24
`define SCR_OFF_REP_DATA    6'h28

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SCR_RST_TYPE        8'h00
`define SCR_RST_OWN_CHAN    8'h01

// ------------------------------------------------------------
// Splitter types
// ------------------------------------------------------------
`define SCR_TYPE_NONE       8'h00
`define SCR_TYPE_QUAD       8'h03

// ------------------------------------------------------------
// Command opcodes
// ------------------------------------------------------------
`define SCR_OP_SET_TYPE     4'h0
`define SCR_OP_GET_TYPE     4'h1
`define SCR_OP_PHASE_WR     4'h2
`define SCR_OP_PHASE_RD     4'h3
`define SCR_OP_MAG_WR       4'h4
`define SCR_OP_MAG_RD       4'h5
`define SCR_OP_DAC_RD       4'h6
`define SCR_OP_DAC_WR       4'h7
`define SCR_OP_DAC_WR_ALIAS 4'h8

// ------------------------------------------------------------
// Channel numbers
// ------------------------------------------------------------
`define SCR_CHAN_BCAST      8'h00
`define SCR_CHAN_ONBOARD    8'hc8

// ------------------------------------------------------------
// Splitter DAC target codes
// ------------------------------------------------------------
`define SCR_TGT_ATT1        4'h1
`define SCR_TGT_ATT2        4'h5
`define SCR_TGT_ATT3        4'h6
`define SCR_TGT_ATT4        4'h2
`define SCR_TGT_PH1         4'h3
`define SCR_TGT_PH2         4'h7
`define SCR_TGT_PH3         4'h4
`define SCR_TGT_PH4         4'h0
`define SCR_TGT_SW_ON       4'he
`define SCR_TGT_SW_OFF      4'hf

// ------------------------------------------------------------
// Count limits
// ------------------------------------------------------------
`define SCR_ATT_MAX         16'h003f
`define SCR_PH_MAX          16'h01ff

// ------------------------------------------------------------
// Status bits
// ------------------------------------------------------------
`define SCR_ST_DONE         0
`define SCR_ST_OK           1
`define SCR_ST_ERR          2
`define SCR_ST_REDIR        3
`define SCR_ST_IGN          4
`define SCR_ST_SWITCH       5

`endif

// >>> rtl/scr_target_decode.v
// Splitter DAC target code decoder
`include "scr_consts.vh"

module scr_target_decode (
  // Target code
  input  wire [3:0] target,
  // Decoded target
  output reg        is_att,
  output reg        is_ph,
  output reg        is_sw_on,
  output reg        is_sw_off,
  output reg  [1:0] idx
);

  // ----------------------------------------------------------
  // Decode
  // ----------------------------------------------------------
  always @* begin
    is_att    = 1'b0;
    is_ph     = 1'b0;
    is_sw_on  = 1'b0;
    is_sw_off = 1'b0;
    idx       = 2'h0;
    case (target)
      `SCR_TGT_ATT1: begin is_att = 1'b1; idx = 2'h0; end
      `SCR_TGT_ATT2: begin is_att = 1'b1; idx = 2'h1; end
      `SCR_TGT_ATT3: begin is_att = 1'b1; idx = 2'h2; end
      `SCR_TGT_ATT4: begin is_att = 1'b1; idx = 2'h3; end
      `SCR_TGT_PH1:  begin is_ph = 1'b1; idx = 2'h0; end
      `SCR_TGT_PH2:  begin is_ph = 1'b1; idx = 2'h1; end
      `SCR_TGT_PH3:  begin is_ph = 1'b1; idx = 2'h2; end
      `SCR_TGT_PH4:  begin is_ph = 1'b1; idx = 2'h3; end
      `SCR_TGT_SW_ON:  is_sw_on = 1'b1;
      `SCR_TGT_SW_OFF: is_sw_off = 1'b1;
      default: idx = 2'h0;
    endcase
  end

endmodule // scr_target_decode

// >>> rtl/scr_splitter_redirector.v
// Splitter command redirector with Avalon-MM register access
//
// Operation
// - Hold splitter type; 0 means inactive, 3 selects the four-way splitter.
// - Splitter type reads 0 after reset.
// - With splitter set, phase and magnitude go to splitter, not onboard.
// - Own channel N accepts splitter channels 4N-3 through 4N.
// - Redirected replies carry the addressed splitter channel number.
// - Broadcast channel 0 hits every splitter channel, not onboard.
// - Channels 200 and up reach onboard; 200 is onboard broadcast.
// - Only phase and magnitude commands change; opcodes 9 to 15 for own or broadcast channel pass unchanged.
// - Gain control stays onboard; redirected commands touch splitter only.
// - DAC target codes map to fixed channel attenuation and phase.
// - Target 14 asserts RF switch, 15 clears it; count ignored.
// - Attenuation counts 0 to 63, half dB per step.
// - Phase counts 0 to 511; bit 8 adds inversion.
// - DAC read answers channel, target and current count.
// - Both DAC write commands act alike and reply channel with OK.
`include "scr_consts.vh"

module scr_splitter_redirector (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Onboard RF chain command port
  output reg         onboard_valid,
  output reg  [3:0]  onboard_op,
  output reg  [7:0]  onboard_chan,
  output reg  [15:0] onboard_value,
  input  wire [15:0] onboard_rdata,
  // Automatic gain control path
  input  wire        agc_valid,
  input  wire [15:0] agc_value,
  output reg         onboard_agc_valid,
  output reg  [15:0] onboard_agc_value,
  // Splitter board settings
  output wire [23:0] split_atten,
  output wire [35:0] split_phase,
  output reg         splitter_rf_switch,
  output reg         split_update
);

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  reg  [7:0]  split_type;
  reg  [7:0]  own_chan;
  reg  [3:0]  cmd_op;
  reg  [7:0]  cmd_chan;
  reg  [3:0]  cmd_target;
  reg  [15:0] cmd_value;
  reg         st_done;
  reg         st_ok;
  reg         st_err;
  reg         st_redir;
  reg         st_ign;
  reg  [7:0]  rep_chan;
  reg  [3:0]  rep_target;
  reg  [15:0] rep_data;
  reg         ack;
  reg  [5:0]  atten_q [0:3];
  reg  [8:0]  phase_q [0:3];

  // ----------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------
  wire        req    = avs_read | avs_write;
  wire        wr_ack = avs_write & ack;
  wire [3:0]  be     = avs_byteenable;
  wire [31:0] bmask  = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  wire        do_go  = wr_ack & (avs_address == `SCR_OFF_GO) & be[0] & avs_writedata[0];

  assign avs_waitrequest = req & ~ack;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  wire [31:0] own_mrg = merge({24'h0, own_chan}, avs_writedata, bmask);
  wire [31:0] val_mrg = merge({16'h0, cmd_value}, avs_writedata, bmask);

  // ----------------------------------------------------------
  // Target decode
  // ----------------------------------------------------------
  wire       t_att;
  wire       t_ph;
  wire       t_on;
  wire       t_off;
  wire [1:0] t_idx;

  scr_target_decode u_decode (
    .target    (cmd_target),
    .is_att    (t_att),
    .is_ph     (t_ph),
    .is_sw_on  (t_on),
    .is_sw_off (t_off),
    .idx       (t_idx)
  );

  // ----------------------------------------------------------
  // Channel mapping
  // ----------------------------------------------------------
  wire [9:0] own4     = {own_chan, 2'b00};
  wire [9:0] base     = own4 - 10'h003;
  wire [9:0] ch10     = {2'b00, cmd_chan};
  wire       split_on = (split_type != `SCR_TYPE_NONE);
  wire       ch_bcast = (cmd_chan == `SCR_CHAN_BCAST);
  wire       ch_onb   = (cmd_chan >= `SCR_CHAN_ONBOARD);
  wire       ch_local = (own_chan != 8'h00) & (ch10 >= base) & (ch10 <= own4);
  wire [9:0] ch_off   = ch10 - base;
  wire [1:0] sp_idx   = ch_off[1:0];
  wire [7:0] onb_chan = cmd_chan - `SCR_CHAN_ONBOARD;
  wire       for_me   = ch_bcast | (cmd_chan == own_chan);
  wire       is_pm    = (cmd_op == `SCR_OP_PHASE_WR) | (cmd_op == `SCR_OP_PHASE_RD)
                      | (cmd_op == `SCR_OP_MAG_WR) | (cmd_op == `SCR_OP_MAG_RD);
  wire       is_ph_op = (cmd_op == `SCR_OP_PHASE_WR) | (cmd_op == `SCR_OP_PHASE_RD);
  wire       is_wr_op = (cmd_op == `SCR_OP_PHASE_WR) | (cmd_op == `SCR_OP_MAG_WR);

  // ----------------------------------------------------------
  // Command execution decode
  // ----------------------------------------------------------
  reg        e_ok;
  reg        e_err;
  reg        e_ign;
  reg        e_redir;
  reg        e_onb;
  reg  [7:0] e_onb_chan;
  reg  [3:0] e_att_we;
  reg  [3:0] e_ph_we;
  reg        e_sw_set;
  reg        e_sw_clr;
  reg  [7:0] next_type;
  reg        e_type_we;
  reg  [15:0] e_data;
  reg        e_data_onb;

  always @* begin
    e_ok       = 1'b0;
    e_err      = 1'b0;
    e_ign      = 1'b0;
    e_redir    = 1'b0;
    e_onb      = 1'b0;
    e_onb_chan = cmd_chan;
    e_att_we   = 4'h0;
    e_ph_we    = 4'h0;
    e_sw_set   = 1'b0;
    e_sw_clr   = 1'b0;
    next_type  = split_type;
    e_type_we  = 1'b0;
    e_data     = 16'h0000;
    e_data_onb = 1'b0;
    if (is_pm && split_on) begin
      if (ch_onb) begin
        e_onb      = 1'b1;
        e_onb_chan = onb_chan;
        e_ok       = 1'b1;
        e_data_onb = ~is_wr_op;
      end else if (ch_bcast || ch_local) begin
        e_redir = 1'b1;
        if (is_wr_op) begin
          if (cmd_value > (is_ph_op ? `SCR_PH_MAX : `SCR_ATT_MAX)) begin
            e_err = 1'b1;
          end else begin
            e_ok = 1'b1;
            if (is_ph_op) begin
              e_ph_we = ch_bcast ? 4'hf : (4'h1 << sp_idx);
            end else begin
              e_att_we = ch_bcast ? 4'hf : (4'h1 << sp_idx);
            end
          end
        end else begin
          e_ok   = 1'b1;
          e_data = is_ph_op ? {7'h00, phase_q[ch_bcast ? 2'h0 : sp_idx]}
                            : {10'h000, atten_q[ch_bcast ? 2'h0 : sp_idx]};
        end
      end else begin
        e_ign = 1'b1;
      end
    end else if (!for_me) begin
      e_ign = 1'b1;
    end else begin
      case (cmd_op)
        `SCR_OP_SET_TYPE: begin
          if (cmd_value == {8'h00, `SCR_TYPE_NONE} || cmd_value == {8'h00, `SCR_TYPE_QUAD}) begin
            e_ok      = 1'b1;
            e_type_we = 1'b1;
            next_type = cmd_value[7:0];
          end else begin
            e_err = 1'b1;
          end
        end
        `SCR_OP_GET_TYPE: begin
          e_ok   = 1'b1;
          e_data = {8'h00, split_type};
        end
        `SCR_OP_DAC_RD: begin
          if (t_att || t_ph) begin
            e_ok   = 1'b1;
            e_data = t_ph ? {7'h00, phase_q[t_idx]} : {10'h000, atten_q[t_idx]};
          end else begin
            e_err = 1'b1;
          end
        end
        `SCR_OP_DAC_WR, `SCR_OP_DAC_WR_ALIAS: begin
          if (t_on || t_off) begin
            e_ok     = 1'b1;
            e_sw_set = t_on;
            e_sw_clr = t_off;
          end else if (t_att && cmd_value <= `SCR_ATT_MAX) begin
            e_ok     = 1'b1;
            e_att_we = 4'h1 << t_idx;
          end else if (t_ph && cmd_value <= `SCR_PH_MAX) begin
            e_ok    = 1'b1;
            e_ph_we = 4'h1 << t_idx;
          end else begin
            e_err = 1'b1;
          end
        end
        default: begin
          e_onb      = 1'b1;
          e_ok       = 1'b1;
          e_data_onb = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Splitter DAC settings
  // ----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      always @(posedge clk) begin
        if (sys_rst) begin
          atten_q[gi] <= 6'h00;
          phase_q[gi] <= 9'h000;
        end else if (do_go) begin
          if (e_att_we[gi]) begin
            atten_q[gi] <= cmd_value[5:0];
          end
          if (e_ph_we[gi]) begin
            phase_q[gi] <= cmd_value[8:0];
          end
        end
      end
      assign split_atten[gi*6 +: 6] = atten_q[gi];
      assign split_phase[gi*9 +: 9] = phase_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------
  // Command execution and register writes
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      ack                <= 1'b0;
      split_type         <= `SCR_RST_TYPE;
      own_chan           <= `SCR_RST_OWN_CHAN;
      cmd_op             <= 4'h0;
      cmd_chan           <= 8'h00;
      cmd_target         <= 4'h0;
      cmd_value          <= 16'h0000;
      st_done            <= 1'b0;
      st_ok              <= 1'b0;
      st_err             <= 1'b0;
      st_redir           <= 1'b0;
      st_ign             <= 1'b0;
      rep_chan           <= 8'h00;
      rep_target         <= 4'h0;
      rep_data           <= 16'h0000;
      onboard_valid      <= 1'b0;
      onboard_op         <= 4'h0;
      onboard_chan       <= 8'h00;
      onboard_value      <= 16'h0000;
      onboard_agc_valid  <= 1'b0;
      onboard_agc_value  <= 16'h0000;
      splitter_rf_switch <= 1'b0;
      split_update       <= 1'b0;
    end else begin
      ack               <= req & ~ack;
      onboard_agc_valid <= agc_valid;
      onboard_agc_value <= agc_value;
      onboard_valid     <= do_go & e_onb;
      split_update      <= do_go & ((|e_att_we) | (|e_ph_we) | e_sw_set | e_sw_clr);
      if (do_go && e_onb) begin
        onboard_op    <= cmd_op;
        onboard_chan  <= e_onb_chan;
        onboard_value <= cmd_value;
      end
      if (wr_ack) begin
        case (avs_address)
          `SCR_OFF_OWN_CHAN:   own_chan   <= own_mrg[7:0];
          `SCR_OFF_CMD_OP:     cmd_op     <= be[0] ? avs_writedata[3:0] : cmd_op;
          `SCR_OFF_CMD_CHAN:   cmd_chan   <= be[0] ? avs_writedata[7:0] : cmd_chan;
          `SCR_OFF_CMD_TARGET: cmd_target <= be[0] ? avs_writedata[3:0] : cmd_target;
          `SCR_OFF_CMD_VALUE:  cmd_value  <= val_mrg[15:0];
          `SCR_OFF_STATUS:     st_done    <= 1'b0;
          default:             st_done    <= st_done;
        endcase
      end
      if (do_go) begin
        st_done    <= 1'b1;
        st_ok      <= e_ok;
        st_err     <= e_err;
        st_redir   <= e_redir;
        st_ign     <= e_ign;
        rep_chan   <= cmd_chan;
        rep_target <= cmd_target;
        rep_data   <= e_data_onb ? onboard_rdata : e_data;
        if (e_type_we) begin
          split_type <= next_type;
        end
        if (e_sw_set) begin
          splitter_rf_switch <= 1'b1;
        end else if (e_sw_clr) begin
          splitter_rf_switch <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack) begin
      case (avs_address)
        `SCR_OFF_TYPE:       avs_readdata <= {24'h000000, split_type};
        `SCR_OFF_OWN_CHAN:   avs_readdata <= {24'h000000, own_chan};
        `SCR_OFF_CMD_OP:     avs_readdata <= {28'h0000000, cmd_op};
        `SCR_OFF_CMD_CHAN:   avs_readdata <= {24'h000000, cmd_chan};
        `SCR_OFF_CMD_TARGET: avs_readdata <= {28'h0000000, cmd_target};
        `SCR_OFF_CMD_VALUE:  avs_readdata <= {16'h0000, cmd_value};
        `SCR_OFF_STATUS:     avs_readdata <= {26'h0, splitter_rf_switch, st_ign,
                                              st_redir, st_err, st_ok, st_done};
        `SCR_OFF_REP_CHAN:   avs_readdata <= {24'h000000, rep_chan};
        `SCR_OFF_REP_TARGET: avs_readdata <= {28'h0000000, rep_target};
        `SCR_OFF_REP_DATA:   avs_readdata <= {16'h0000, rep_data};
        default:             avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule // scr_splitter_redirector

// >>> tb/scr_checker.sv
// Concurrent checks on the splitter command redirector ports
module scr_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // Onboard chain
  input wire logic        onboard_valid,
  input wire logic [7:0]  onboard_chan,
  input wire logic [15:0] onboard_value,
  input wire logic        agc_valid,
  input wire logic [15:0] agc_value,
  input wire logic        onboard_agc_valid,
  input wire logic [15:0] onboard_agc_value,
  // Splitter side
  input wire logic [23:0] split_atten,
  input wire logic [35:0] split_phase,
  input wire logic        splitter_rf_switch,
  input wire logic        split_update
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  a_split_only: assert property (split_update |-> !onboard_valid)
    else $error("splitter update also forwarded onboard");
  a_onb_pulse: assert property (onboard_valid |=> !onboard_valid)
    else $error("onboard pulse too long");
  a_onb_held: assert property ($changed(onboard_value) || $changed(onboard_chan)
    |-> ##[0:1] onboard_valid) else $error("onboard fields moved without forward");
  a_agc_copy: assert property (agc_valid |=> onboard_agc_valid
    && onboard_agc_value == $past(agc_value)) else $error("gain path not copied");
  a_agc_idle: assert property (!agc_valid |=> !onboard_agc_valid)
    else $error("gain path without cause");
  a_atten_upd: assert property ($changed(split_atten) |-> split_update)
    else $error("attenuation moved without update");
  a_phase_upd: assert property ($changed(split_phase) |-> split_update)
    else $error("phase moved without update");
  a_switch_upd: assert property ($changed(splitter_rf_switch) |-> split_update)
    else $error("switch moved without update");
  a_upd_pulse: assert property (split_update |=> !split_update)
    else $error("update pulse too long");

  c_upd: cover property (split_update);
  c_onb: cover property (onboard_valid);
  c_sw: cover property ($rose(splitter_rf_switch));
endmodule // scr_checker

bind scr_splitter_redirector scr_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .onboard_valid(onboard_valid),
  .onboard_chan(onboard_chan), .onboard_value(onboard_value), .agc_valid(agc_valid),
  .agc_value(agc_value), .onboard_agc_valid(onboard_agc_valid),
  .onboard_agc_value(onboard_agc_value), .split_atten(split_atten),
  .split_phase(split_phase), .splitter_rf_switch(splitter_rf_switch),
  .split_update(split_update)
);

// >>> tb/scr_onboard_model.sv
// Onboard RF chain model that remembers the last written value
`include "scr_consts.vh"
module scr_onboard_model (
  // Clock
  input wire logic        clk,
  // Forwarded command
  input wire logic        onboard_valid,
  input wire logic [3:0]  onboard_op,
  input wire logic [15:0] onboard_value,
  // Reply
  output logic     [15:0] onboard_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial onboard_rdata = 16'h0;
  always @(posedge clk) begin
    if (onboard_valid === 1'b1 && (onboard_op == `SCR_OP_PHASE_WR ||
        onboard_op == `SCR_OP_MAG_WR)) begin
      onboard_rdata <= onboard_value;
    end
  end
endmodule // scr_onboard_model

// >>> tb/tb_splitter_command_redirector.sv
// Testbench for the splitter command redirector
`include "scr_consts.vh"
module tb_splitter_command_redirector;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, avs_read, avs_write, agc_valid, avs_waitrequest;
  logic        onboard_valid, onboard_agc_valid, splitter_rf_switch, split_update;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  onboard_op;
  logic [7:0]  onboard_chan;
  logic [15:0] onboard_value, onboard_rdata, agc_value, onboard_agc_value;
  logic [23:0] split_atten;
  logic [35:0] split_phase;
  int          err_count = 0, checks_done = 0, n_onb = 0, k;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  scr_splitter_redirector dut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .onboard_valid(onboard_valid), .onboard_op(onboard_op), .onboard_chan(onboard_chan),
    .onboard_value(onboard_value), .onboard_rdata(onboard_rdata), .agc_valid(agc_valid),
    .agc_value(agc_value), .onboard_agc_valid(onboard_agc_valid),
    .onboard_agc_value(onboard_agc_value), .split_atten(split_atten),
    .split_phase(split_phase), .splitter_rf_switch(splitter_rf_switch),
    .split_update(split_update));

  scr_onboard_model u_onb (.clk(clk), .onboard_valid(onboard_valid),
    .onboard_op(onboard_op), .onboard_value(onboard_value), .onboard_rdata(onboard_rdata));

  always @(posedge clk) begin
    if (onboard_valid === 1'b1) n_onb++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
    if (n >= 20) chk(1, 0);
  endtask

  task automatic cmd(input logic [3:0] op, input logic [7:0] ch, input logic [3:0] tg,
                     input logic [15:0] v);
    bus(1, `SCR_OFF_CMD_OP, {28'h0, op});
    bus(1, `SCR_OFF_CMD_CHAN, {24'h0, ch});
    bus(1, `SCR_OFF_CMD_TARGET, {28'h0, tg});
    bus(1, `SCR_OFF_CMD_VALUE, {16'h0, v});
    bus(1, `SCR_OFF_GO, 32'h1);
    bus(0, `SCR_OFF_STATUS, 32'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    bus(0, `SCR_OFF_TYPE, 32'h0);
    chk(rd, 32'h0);
    bus(0, 6'h3c, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_type;
    k = n_onb;
    cmd(`SCR_OP_PHASE_WR, 8'h01, 4'h0, 16'h2a);
    chk(n_onb - k, 1);
    chk(split_phase, 36'h0);
    cmd(`SCR_OP_SET_TYPE, 8'h01, 4'h0, 16'h5);
    chk(rd[2:1], 2'b10);
    cmd(`SCR_OP_SET_TYPE, 8'h01, 4'h0, 16'h3);
    bus(0, `SCR_OFF_TYPE, 32'h0);
    chk(rd, 32'h3);
  endtask

  task automatic t_redir;
    bus(1, `SCR_OFF_OWN_CHAN, 32'h2);
    k = n_onb;
    cmd(`SCR_OP_PHASE_WR, 8'h07, 4'h0, 16'h12c);
    chk(rd[3:1], 3'b101);
    chk(split_phase[26:18], 9'h12c);
    cmd(`SCR_OP_MAG_WR, 8'h08, 4'h0, 16'h14);
    chk(split_atten[23:18], 6'h14);
    cmd(`SCR_OP_PHASE_RD, 8'h07, 4'h0, 16'h0);
    bus(0, `SCR_OFF_REP_CHAN, 32'h0);
    chk(rd, 32'h7);
    bus(0, `SCR_OFF_REP_DATA, 32'h0);
    chk(rd, 32'h12c);
    cmd(`SCR_OP_MAG_WR, 8'h04, 4'h0, 16'h1);
    chk(rd[4], 1'b1);
    cmd(`SCR_OP_MAG_WR, 8'h09, 4'h0, 16'h1);
    chk(rd[4], 1'b1);
    chk(n_onb - k, 0);
  endtask

  task automatic t_bcast;
    k = n_onb;
    cmd(`SCR_OP_MAG_WR, `SCR_CHAN_BCAST, 4'h0, 16'h28);
    chk(split_atten, {4{6'h28}});
    chk(n_onb - k, 0);
  endtask

  task automatic t_onboard;
    k = n_onb;
    cmd(`SCR_OP_PHASE_WR, 8'hc9, 4'h0, 16'h4d);
    chk(n_onb - k, 1);
    chk(onboard_chan, 8'h01);
    chk(onboard_value, 16'h4d);
    cmd(`SCR_OP_PHASE_RD, 8'hc8, 4'h0, 16'h0);
    chk(onboard_chan, 8'h00);
    bus(0, `SCR_OFF_REP_DATA, 32'h0);
    chk(rd, 32'h4d);
  endtask

  task automatic t_other;
    k = n_onb;
    cmd(4'h9, 8'h02, 4'h0, 16'h0);
    chk(n_onb - k, 1);
    chk(onboard_op, 4'h9);
    chk(split_atten, {4{6'h28}});
  endtask

  task automatic t_agc;
    agc_valid <= 1'b1;
    agc_value <= 16'hbeef;
    @(posedge clk);
    agc_valid <= 1'b0;
    @(negedge clk);
    chk(onboard_agc_valid, 1'b1);
    chk(onboard_agc_value, 16'hbeef);
    @(posedge clk);
  endtask

  task automatic t_dac;
    logic [3:0] att_t [4];
    logic [3:0] ph_t [4];
    att_t = '{4'h1, 4'h5, 4'h6, 4'h2};
    ph_t  = '{4'h3, 4'h7, 4'h4, 4'h0};
    for (int i = 0; i < 4; i++) begin
      cmd(i[0] ? `SCR_OP_DAC_WR_ALIAS : `SCR_OP_DAC_WR, 8'h02, att_t[i], 16'(16'h3c + i));
      chk(rd[2:1], 2'b01);
      chk(split_atten[6*i +: 6], 6'(6'h3c + i));
      cmd(`SCR_OP_DAC_WR, 8'h02, ph_t[i], 16'(16'h1fc + i));
      chk(split_phase[9*i +: 9], 9'(9'h1fc + i));
      cmd(`SCR_OP_DAC_RD, 8'h02, ph_t[i], 16'h0);
      bus(0, `SCR_OFF_REP_DATA, 32'h0);
      chk(rd, 32'(32'h1fc + i));
    end
    bus(0, `SCR_OFF_REP_CHAN, 32'h0);
    chk(rd, 32'h2);
    cmd(`SCR_OP_DAC_WR, 8'h02, 4'h1, 16'h40);
    chk(rd[2:1], 2'b10);
    chk(split_atten[5:0], 6'h3c);
    cmd(`SCR_OP_DAC_WR, 8'h02, 4'h3, 16'h200);
    chk(split_phase[8:0], 9'h1fc);
    cmd(`SCR_OP_DAC_WR, 8'h02, 4'h8, 16'h0);
    chk(rd[2:1], 2'b10);
    cmd(`SCR_OP_DAC_WR_ALIAS, 8'h02, 4'he, 16'h0);
    chk(splitter_rf_switch, 1'b1);
    cmd(`SCR_OP_DAC_WR, 8'h02, 4'hf, 16'h0);
    chk(splitter_rf_switch, 1'b0);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    agc_valid = 1'b0;
    agc_value = 16'h0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_type;
    t_redir;
    t_bcast;
    t_onboard;
    t_other;
    t_agc;
    t_dac;
    give_verdict;
  end

  initial begin
    #60us;
    err_count++;
    give_verdict;
  end
endmodule // tb_splitter_command_redirector
